// ===== common/pkt_map.svh
`ifndef PKT_MAP_SVH
`define PKT_MAP_SVH
`define NUM_DEV 4
`define DEV_W 2
`define BANK_W 5
`define COLA_W 6
`define ROWA_W 9
`define CNT_W 8
`define CLK_NS 100
`define T_CC_NS 100
`define T_CAC_NS 300
`define T_CWD_NS 200
`define T_RTR_NS 300
`define T_RDP_NS 200
`define T_RTP_NS 200
`define T_CC_CYC ((`T_CC_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RW_CYC ((`T_CC_NS + `T_CAC_NS - `T_CWD_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RTR_CYC ((`T_RTR_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RDP_CYC ((`T_RDP_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RTP_CYC ((`T_RTP_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== common/pkt_pkg.sv
`default_nettype none
package pkt_pkg;
	`include "pkt_map.svh"
	typedef logic [`DEV_W-1:0] dev_t;
	typedef logic [`BANK_W-1:0] bank_t;
	typedef logic [`CNT_W-1:0] cnt_t;
	typedef enum logic [2:0] {column_no_operation = 3'h0, col_read = 3'h1, col_write = 3'h2,
		column_precharge_cmd = 3'h3, read_with_autoprecharge = 3'h4,
		write_with_autoprecharge = 3'h5} col_cmd_e;
	typedef enum logic [2:0] {row_no_operation = 3'h0, row_activate = 3'h1, row_precharge_cmd = 3'h2,
		refresh_activate_cmd = 3'h3, refresh_precharge_cmd = 3'h4} row_cmd_e;
	typedef enum logic [1:0] {cls_nop = 2'h0, cls_rd = 2'h1, cls_wr = 2'h2} col_class_e;
	// autoprecharge variants space like their plain forms
	function automatic col_class_e col_class(input col_cmd_e c);
		unique case (c)
			col_read, read_with_autoprecharge: col_class = cls_rd;
			col_write, write_with_autoprecharge: col_class = cls_wr;
			default: col_class = cls_nop;
		endcase
	endfunction
	// shared sense amplifiers make a bank and its neighbours one group (banks 0 and 31 have only one)
	function automatic logic near_bank(input bank_t a, input bank_t b);
		near_bank = (a == b) || ({1'b0, a} == {1'b0, b} + 6'h01) || ({1'b0, b} == {1'b0, a} + 6'h01);
	endfunction
endpackage
`default_nettype wire

// ===== common/trk_if.sv
`default_nettype none
interface trk_if;
	import pkt_pkg::*;
	logic col_fire;
	col_class_e col_cls;
	logic col_pre;
	dev_t col_dev;
	bank_t col_bank;
	logic row_fire;
	logic row_act;
	logic row_pre;
	dev_t row_dev;
	bank_t row_bank;
	logic wb_pending;
	logic act_valid;
	logic rd_busy;
	logic rt_busy;
	bank_t wb_bank;
	bank_t act_bank;
	bank_t rd_bank;
	bank_t rt_bank;
	modport ctrl(output col_fire, col_cls, col_pre, col_dev, col_bank, row_fire, row_act, row_pre,
		row_dev, row_bank, input wb_pending, act_valid, rd_busy, rt_busy, wb_bank, act_bank,
		rd_bank, rt_bank);
	modport tracker(input col_fire, col_cls, col_pre, col_dev, col_bank, row_fire, row_act,
		row_pre, row_dev, row_bank, output wb_pending, act_valid, rd_busy, rt_busy, wb_bank,
		act_bank, rd_bank, rt_bank);
endinterface
`default_nettype wire

// ===== rtl/dev_track.sv
`default_nettype none
`include "pkt_map.svh"
module dev_track #(
	parameter pkt_pkg::dev_t DEV_ID = '0
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	trk_if.tracker bus
);
	import pkt_pkg::*;
	localparam cnt_t RDP_LOAD = cnt_t'(`T_RDP_CYC - 1);
	localparam cnt_t RTP_LOAD = cnt_t'(`T_RTP_CYC - 1);
	logic mine_col;
	logic mine_row;
	logic retire;
	cnt_t rd_cnt;
	cnt_t rt_cnt;
	assign mine_col = bus.col_fire && (bus.col_dev == DEV_ID);
	assign mine_row = bus.row_fire && (bus.row_dev == DEV_ID);
	assign retire = bus.wb_pending && bus.col_fire && !(mine_col && bus.col_cls == cls_rd);
	assign bus.rd_busy = (rd_cnt != '0);
	assign bus.rt_busy = (rt_cnt != '0);

	// write buffer: a new write wins over the retire it causes
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			bus.wb_pending <= 1'b0;
			bus.wb_bank <= '0;
		end else if (mine_col && bus.col_cls == cls_wr) begin
			bus.wb_pending <= 1'b1;
			bus.wb_bank <= bus.col_bank;
		end else if (retire) begin
			bus.wb_pending <= 1'b0;
		end
	end

	// retire and read timers hold off precharges near the touched bank
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			rt_cnt <= '0;
			bus.rt_bank <= '0;
		end else if (retire) begin
			rt_cnt <= RTP_LOAD;
			bus.rt_bank <= bus.wb_bank;
		end else if (rt_cnt != '0) begin
			rt_cnt <= rt_cnt - cnt_t'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			rd_cnt <= '0;
			bus.rd_bank <= '0;
		end else if (mine_col && bus.col_cls == cls_rd) begin
			rd_cnt <= RDP_LOAD;
			bus.rd_bank <= bus.col_bank;
		end else if (rd_cnt != '0) begin
			rd_cnt <= rd_cnt - cnt_t'(1);
		end
	end

	// open bank; any precharge within the group closes it
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			bus.act_valid <= 1'b0;
			bus.act_bank <= '0;
		end else if (mine_row && bus.row_act) begin
			bus.act_valid <= 1'b1;
			bus.act_bank <= bus.row_bank;
		end else if (mine_row && bus.row_pre && near_bank(bus.row_bank, bus.act_bank)) begin
			bus.act_valid <= 1'b0;
		end else if (mine_col && bus.col_pre && near_bank(bus.col_bank, bus.act_bank)) begin
			bus.act_valid <= 1'b0;
		end
	end
endmodule // dev_track
`default_nettype wire

// ===== rtl/col_spacing_ctrl.sv
`default_nettype none
`include "pkt_map.svh"
module col_spacing_ctrl (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic col_valid_in,
	output logic col_ready_out,
	input wire pkt_pkg::col_cmd_e col_cmd_in,
	input wire pkt_pkg::dev_t col_dev_in,
	input wire pkt_pkg::bank_t col_bank_in,
	input wire logic [`COLA_W-1:0] col_addr_in,
	input wire logic row_valid_in,
	output logic row_ready_out,
	input wire pkt_pkg::row_cmd_e row_cmd_in,
	input wire pkt_pkg::dev_t row_dev_in,
	input wire pkt_pkg::bank_t row_bank_in,
	input wire logic [`ROWA_W-1:0] row_addr_in,
	output logic col_pkt_valid_out,
	output pkt_pkg::col_cmd_e col_pkt_cmd_out,
	output pkt_pkg::dev_t col_pkt_dev_out,
	output pkt_pkg::bank_t col_pkt_bank_out,
	output logic [`COLA_W-1:0] col_pkt_addr_out,
	output logic row_pkt_valid_out,
	output pkt_pkg::row_cmd_e row_pkt_cmd_out,
	output pkt_pkg::dev_t row_pkt_dev_out,
	output pkt_pkg::bank_t row_pkt_bank_out,
	output logic [`ROWA_W-1:0] row_pkt_addr_out,
	output logic row_reject_out
);
	import pkt_pkg::*;
	localparam cnt_t TCC = cnt_t'(`T_CC_CYC);
	localparam cnt_t RWG = cnt_t'(`T_RW_CYC);
	localparam cnt_t RTRG = cnt_t'(`T_RTR_CYC);
	localparam cnt_t RDPG = cnt_t'(`T_RDP_CYC);
	typedef enum logic [1:0] {cs_ready = 2'b00, cs_retire = 2'b01, cs_rtr = 2'b11} col_state_e;

	// ----------------------------------------------------------------
	// per-device trackers
	// ----------------------------------------------------------------
	logic [`NUM_DEV-1:0] wb_pending_v;
	logic [`NUM_DEV-1:0] act_valid_v;
	logic [`NUM_DEV-1:0] rd_busy_v;
	logic [`NUM_DEV-1:0] rt_busy_v;
	bank_t wb_bank_a [`NUM_DEV];
	bank_t act_bank_a [`NUM_DEV];
	bank_t rd_bank_a [`NUM_DEV];
	bank_t rt_bank_a [`NUM_DEV];
	logic issue;
	col_cmd_e issue_cmd;
	dev_t issue_dev;
	bank_t issue_bank;
	logic row_fire;
	logic row_act;
	logic row_pre;

	for (genvar g = 0; g < `NUM_DEV; g++) begin : g_dev
		trk_if trk();
		assign trk.col_fire = issue;
		assign trk.col_cls = col_class(issue_cmd);
		assign trk.col_pre = (issue_cmd == column_precharge_cmd) ||
			(issue_cmd == read_with_autoprecharge) || (issue_cmd == write_with_autoprecharge);
		assign trk.col_dev = issue_dev;
		assign trk.col_bank = issue_bank;
		assign trk.row_fire = row_fire;
		assign trk.row_act = row_act;
		assign trk.row_pre = row_pre;
		assign trk.row_dev = row_dev_in;
		assign trk.row_bank = row_bank_in;
		assign wb_pending_v[g] = trk.wb_pending;
		assign act_valid_v[g] = trk.act_valid;
		assign rd_busy_v[g] = trk.rd_busy;
		assign rt_busy_v[g] = trk.rt_busy;
		assign wb_bank_a[g] = trk.wb_bank;
		assign act_bank_a[g] = trk.act_bank;
		assign rd_bank_a[g] = trk.rd_bank;
		assign rt_bank_a[g] = trk.rt_bank;
		dev_track #(.DEV_ID(dev_t'(g))) u_trk (
			.clk_in(clk_in),
			.resetn_in(resetn_in),
			.bus(trk)
		);
	end

	// ----------------------------------------------------------------
	// column spacing
	// ----------------------------------------------------------------
	col_state_e state;
	cnt_t since;
	col_class_e h1_cls;
	col_class_e h2_cls;
	dev_t h1_dev;
	dev_t h2_dev;
	col_class_e new_cls;
	logic wwr;
	cnt_t need;
	logic go;
	logic user_fire;
	logic nop_fire;
	logic retire_wanted;

	assign new_cls = col_class(col_cmd_in);
	assign wwr = (h2_cls == cls_wr) && (h1_cls == cls_wr) && (new_cls == cls_rd) &&
		(h2_dev == h1_dev) && (h1_dev == col_dev_in);
	assign need = (h1_cls == cls_rd && new_cls == cls_wr) ? RWG : TCC;
	assign go = (state == cs_ready && !wwr && since >= need) || (state == cs_rtr && since >= RTRG);
	assign col_ready_out = go;
	assign user_fire = col_valid_in && go;
	// a forced retire only fills idle slots, so user traffic is never delayed by it
	assign nop_fire = (since >= TCC) && ((state == cs_retire) ||
		(state == cs_ready && col_valid_in && wwr) ||
		(state == cs_ready && !col_valid_in && retire_wanted));
	assign issue = user_fire || nop_fire;
	assign issue_cmd = nop_fire ? column_no_operation : col_cmd_in;
	assign issue_dev = nop_fire ? dev_t'(0) : col_dev_in;
	assign issue_bank = nop_fire ? bank_t'(0) : col_bank_in;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state <= cs_ready;
		end else begin
			unique case (state)
				cs_ready: if (col_valid_in && wwr) state <= nop_fire ? cs_rtr : cs_retire;
				cs_retire: if (nop_fire) state <= cs_rtr;
				cs_rtr: if (user_fire) state <= cs_ready;
				default: state <= cs_ready;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			since <= '1;
		end else if (issue) begin
			since <= cnt_t'(1);
		end else if (since != '1) begin
			since <= since + cnt_t'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			h1_cls <= cls_nop;
			h2_cls <= cls_nop;
			h1_dev <= '0;
			h2_dev <= '0;
		end else if (issue) begin
			h1_cls <= col_class(issue_cmd);
			h2_cls <= h1_cls;
			h1_dev <= issue_dev;
			h2_dev <= h1_dev;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			col_pkt_valid_out <= 1'b0;
			col_pkt_cmd_out <= column_no_operation;
			col_pkt_dev_out <= '0;
			col_pkt_bank_out <= '0;
			col_pkt_addr_out <= '0;
		end else begin
			col_pkt_valid_out <= issue;
			if (issue) begin
				col_pkt_cmd_out <= issue_cmd;
				col_pkt_dev_out <= issue_dev;
				col_pkt_bank_out <= issue_bank;
				col_pkt_addr_out <= nop_fire ? '0 : col_addr_in;
			end
		end
	end

	// ----------------------------------------------------------------
	// row checks
	// ----------------------------------------------------------------
	logic act_conflict;
	logic rd_hit;
	logic rt_hit;
	logic wb_hit;
	logic col_hit;
	logic row_take;
	assign row_act = (row_cmd_in == row_activate) || (row_cmd_in == refresh_activate_cmd);
	assign row_pre = (row_cmd_in == row_precharge_cmd) || (row_cmd_in == refresh_precharge_cmd);
	assign act_conflict = row_act && act_valid_v[row_dev_in] &&
		near_bank(act_bank_a[row_dev_in], row_bank_in);
	assign rd_hit = rd_busy_v[row_dev_in] && near_bank(rd_bank_a[row_dev_in], row_bank_in);
	assign rt_hit = rt_busy_v[row_dev_in] && near_bank(rt_bank_a[row_dev_in], row_bank_in);
	assign wb_hit = wb_pending_v[row_dev_in] && near_bank(wb_bank_a[row_dev_in], row_bank_in);
	// a read or retire in this very cycle has not reached its tracker yet
	assign col_hit = issue && (issue_dev == row_dev_in) && near_bank(issue_bank, row_bank_in) &&
		(col_class(issue_cmd) != cls_nop || wb_pending_v[row_dev_in]);
	assign row_ready_out = !(row_pre && (rd_hit || rt_hit || wb_hit || col_hit));
	assign retire_wanted = row_valid_in && row_pre && wb_hit;
	assign row_take = row_valid_in && row_ready_out;
	assign row_fire = row_take && !act_conflict;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			row_pkt_valid_out <= 1'b0;
			row_reject_out <= 1'b0;
			row_pkt_cmd_out <= row_no_operation;
			row_pkt_dev_out <= '0;
			row_pkt_bank_out <= '0;
			row_pkt_addr_out <= '0;
		end else begin
			row_pkt_valid_out <= row_fire;
			row_reject_out <= row_take && act_conflict;
			if (row_fire) begin
				row_pkt_cmd_out <= row_cmd_in;
				row_pkt_dev_out <= row_dev_in;
				row_pkt_bank_out <= row_bank_in;
				row_pkt_addr_out <= row_addr_in;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks on the issued packets
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	cnt_t gap;
	cnt_t rd_gap;
	logic o_seen;
	logic rd_seen;
	col_class_e o1_cls;
	col_class_e o2_cls;
	dev_t o1_dev;
	dev_t o2_dev;
	dev_t rd_dev_o;
	bank_t rd_bank_o;
	col_class_e out_cls;
	assign out_cls = col_class(col_pkt_cmd_out);
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			gap <= '1;
			rd_gap <= '1;
			o_seen <= 1'b0;
			rd_seen <= 1'b0;
			o1_cls <= cls_nop;
			o2_cls <= cls_nop;
			o1_dev <= '0;
			o2_dev <= '0;
			rd_dev_o <= '0;
			rd_bank_o <= '0;
		end else begin
			gap <= col_pkt_valid_out ? cnt_t'(1) : (gap == '1 ? gap : gap + cnt_t'(1));
			rd_gap <= (col_pkt_valid_out && out_cls == cls_rd) ? cnt_t'(1) :
				(rd_gap == '1 ? rd_gap : rd_gap + cnt_t'(1));
			if (col_pkt_valid_out) begin
				o_seen <= 1'b1;
				o1_cls <= out_cls;
				o2_cls <= o1_cls;
				o1_dev <= col_pkt_dev_out;
				o2_dev <= o1_dev;
			end
			if (col_pkt_valid_out && out_cls == cls_rd) begin
				rd_seen <= 1'b1;
				rd_dev_o <= col_pkt_dev_out;
				rd_bank_o <= col_pkt_bank_out;
			end
		end
	end
	a_cc_min_gap: assert property (col_pkt_valid_out && o_seen |-> gap >= TCC)
		else $error("column packets closer than one column period");
	a_rd_wr_gap: assert property (col_pkt_valid_out && out_cls == cls_wr && o1_cls == cls_rd
		|-> gap >= RWG)
		else $error("write follows read too early");
	a_no_wwr_run: assert property (col_pkt_valid_out && out_cls == cls_rd && o1_cls == cls_wr &&
		o2_cls == cls_wr |-> !(o1_dev == col_pkt_dev_out && o2_dev == o1_dev))
		else $error("write write read run to one device");
	a_retire_nop_sent: assert property (state == cs_ready && col_valid_in && wwr |-> ##[1:260]
		(col_pkt_valid_out && col_pkt_cmd_out == column_no_operation))
		else $error("retire no-operation not sent");
	a_act_reject: assert property (row_take && act_conflict |=> row_reject_out &&
		!row_pkt_valid_out)
		else $error("conflicting activate was issued");
	a_refresh_reject: assert property (row_valid_in && row_cmd_in == refresh_activate_cmd &&
		act_conflict && row_ready_out |=> row_reject_out)
		else $error("refresh activate not checked like activate");
	a_pre_after_read: assert property (row_pkt_valid_out && rd_seen &&
		(row_pkt_cmd_out == row_precharge_cmd || row_pkt_cmd_out == refresh_precharge_cmd) &&
		row_pkt_dev_out == rd_dev_o && near_bank(rd_bank_o, row_pkt_bank_out) &&
		!(col_pkt_valid_out && out_cls == cls_rd) |-> rd_gap >= RDPG)
		else $error("precharge too soon after read");
	a_pre_wb_retired: assert property (row_fire && row_pre |-> !wb_hit && !rt_hit)
		else $error("precharge over an unretired write");
	a_pre_stall_retire: assert property (retire_wanted && !col_valid_in && state == cs_ready
		|-> ##[0:260] (issue && issue_cmd == column_no_operation))
		else $error("stalled precharge never forced a retire");
	c_wwr_run: cover property (state == cs_ready && col_valid_in && wwr && nop_fire ##1
		state == cs_rtr ##[1:20] user_fire);
	c_rd_wr: cover property (col_pkt_valid_out && out_cls == cls_wr && o1_cls == cls_rd);
	c_reject: cover property (row_reject_out);
	c_pre_stall: cover property (row_valid_in && row_pre && !row_ready_out ##[1:20] row_fire);
endmodule // col_spacing_ctrl
`default_nettype wire

// ===== dv/dev_model.sv
`default_nettype none
`include "pkt_map.svh"
// ----------------------------------------
// device side: write buffer, open banks
// ----------------------------------------
module dev_model (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic col_v_in,
	input wire pkt_pkg::col_cmd_e col_c_in,
	input wire pkt_pkg::dev_t col_d_in,
	input wire pkt_pkg::bank_t col_b_in,
	input wire logic row_v_in,
	input wire pkt_pkg::row_cmd_e row_c_in,
	input wire pkt_pkg::dev_t row_d_in,
	input wire pkt_pkg::bank_t row_b_in,
	output int bad_out
);
	import pkt_pkg::*;
	logic wb_v[`NUM_DEV];
	bank_t wb_b[`NUM_DEV];
	logic op_v[`NUM_DEV];
	bank_t op_b[`NUM_DEV];
	// no wrap at the ends of the bank range
	function automatic logic adj(bank_t a, bank_t b);
		return (a == b) || (a + 5'h01 == b && a != 5'h1f) || (b + 5'h01 == a && b != 5'h1f);
	endfunction
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			// fault count survives the resets between scenarios
			for (int i = 0; i < `NUM_DEV; i++) begin
				wb_v[i] <= 1'b0;
				op_v[i] <= 1'b0;
			end
		end else begin
			if (col_v_in) begin
				for (int i = 0; i < `NUM_DEV; i++) begin
					if (!(col_c_in inside {col_read, read_with_autoprecharge} && col_d_in == i)) begin
						wb_v[i] <= 1'b0;
					end
				end
				if (col_c_in inside {col_write, write_with_autoprecharge}) begin
					wb_v[col_d_in] <= 1'b1;
					wb_b[col_d_in] <= col_b_in;
				end
				if (col_c_in inside {column_precharge_cmd, read_with_autoprecharge,
					write_with_autoprecharge} && adj(op_b[col_d_in], col_b_in)) begin
					op_v[col_d_in] <= 1'b0;
				end
			end
			if (row_v_in && row_c_in inside {row_activate, refresh_activate_cmd}) begin
				// neighbours of an open bank share its sense amps
				if (op_v[row_d_in] && adj(op_b[row_d_in], row_b_in)) begin
					bad_out <= bad_out + 1;
				end
				op_v[row_d_in] <= 1'b1;
				op_b[row_d_in] <= row_b_in;
			end
			if (row_v_in && row_c_in inside {row_precharge_cmd, refresh_precharge_cmd}) begin
				if (wb_v[row_d_in] && adj(wb_b[row_d_in], row_b_in)) begin
					bad_out <= bad_out + 1;
				end
				if (adj(op_b[row_d_in], row_b_in)) begin
					op_v[row_d_in] <= 1'b0;
				end
			end
		end
	end
endmodule // dev_model
`default_nettype wire

// ===== dv/test_col_spacing_ctrl.sv
`default_nettype none
`include "pkt_map.svh"
module test_col_spacing_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	import pkt_pkg::*;
	logic clk_in, resetn_in, cv, rv, c_rdy, r_rdy, cpv, rpv, rej;
	col_cmd_e cc, pcmd;
	row_cmd_e rc;
	dev_t cd, rd;
	bank_t cb, rb;
	dev_t pdev, prd;
	bank_t pbank, prb;
	row_cmd_e prc;
	logic [`COLA_W-1:0] paddr;
	logic [`ROWA_W-1:0] raddr;
	int err_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int bad;
	int pc[$];
	int rcq[$];
	int rjq[$];
	col_cmd_e pk[$];
	col_spacing_ctrl col_spacing_ctrl_inst (.clk_in(clk_in), .resetn_in(resetn_in),
		.col_valid_in(cv), .col_ready_out(c_rdy), .col_cmd_in(cc), .col_dev_in(cd),
		.col_bank_in(cb), .col_addr_in({1'b0, cb}), .row_valid_in(rv), .row_ready_out(r_rdy),
		.row_cmd_in(rc), .row_dev_in(rd), .row_bank_in(rb), .row_addr_in({4'h0, rb}),
		.col_pkt_valid_out(cpv), .col_pkt_cmd_out(pcmd), .col_pkt_dev_out(pdev),
		.col_pkt_bank_out(pbank), .col_pkt_addr_out(paddr), .row_pkt_valid_out(rpv),
		.row_pkt_cmd_out(prc), .row_pkt_dev_out(prd), .row_pkt_bank_out(prb),
		.row_pkt_addr_out(raddr), .row_reject_out(rej));
	dev_model dev_model_inst (.clk_in(clk_in), .resetn_in(resetn_in), .col_v_in(cpv),
		.col_c_in(pcmd), .col_d_in(pdev), .col_b_in(pbank), .row_v_in(rpv), .row_c_in(prc),
		.row_d_in(prd), .row_b_in(prb), .bad_out(bad));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// packet log in cycle numbers, cleared at each reset release
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cpv === 1'b1) begin
			pc.push_back(cyc);
			pk.push_back(pcmd);
		end
		if (rpv === 1'b1) rcq.push_back(cyc);
		if (rej === 1'b1) rjq.push_back(cyc);
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk_gap(string n, int e, int g);
		samples_checked++;
		if (e !== g) begin
			err_count++;
			$display("MISMATCH %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic chk_val(string n, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (e !== g) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic do_reset;
		@(posedge clk_in);
		resetn_in <= 1'b0;
		cv <= 1'b0;
		rv <= 1'b0;
		repeat (5) @(posedge clk_in);
		resetn_in <= 1'b1;
		pc.delete();
		pk.delete();
		rcq.delete();
		rjq.delete();
	endtask
	task automatic idle;
		cv <= 1'b0;
		rv <= 1'b0;
		repeat (8) @(posedge clk_in);
	endtask
	// valid stays up on return so that requests can go back to back
	task automatic col_req(col_cmd_e c, dev_t d, bank_t b);
		int n;
		n = 0;
		cv <= 1'b1;
		cc <= c;
		cd <= d;
		cb <= b;
		do begin
			@(negedge clk_in);
			n++;
		end while (c_rdy !== 1'b1 && n < 40);
		if (n >= 40) begin
			chk_gap("column wait", 0, n);
			end_sim();
		end
		@(posedge clk_in);
	endtask
	task automatic row_req(row_cmd_e c, dev_t d, bank_t b);
		int n;
		n = 0;
		rv <= 1'b1;
		rc <= c;
		rd <= d;
		rb <= b;
		do begin
			@(negedge clk_in);
			n++;
		end while (r_rdy !== 1'b1 && n < 40);
		if (n >= 40) begin
			chk_gap("row wait", 0, n);
			end_sim();
		end
		@(posedge clk_in);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic sc_pairs;
		col_cmd_e a[7] = '{col_read, col_write, col_read, column_no_operation, col_read,
			read_with_autoprecharge, column_precharge_cmd};
		col_cmd_e b[7] = '{col_read, col_write, column_no_operation, col_read, col_write,
			write_with_autoprecharge, col_write};
		int g[7] = '{`T_CC_CYC, `T_CC_CYC, `T_CC_CYC, `T_CC_CYC, `T_RW_CYC, `T_RW_CYC, `T_CC_CYC};
		for (int i = 0; i < 7; i++) begin
			do_reset();
			col_req(a[i], 2'h0, 5'h03);
			col_req(b[i], 2'h0, 5'h03);
			idle();
			chk_gap("pair count", 2, pc.size());
			chk_gap("pair gap", g[i], pc[1] - pc[0]);
			chk_val("col addr", 8'h03, {2'h0, paddr});
		end
	endtask
	task automatic sc_three;
		col_cmd_e ca[5] = '{col_write, col_write, col_write, col_read, column_no_operation};
		dev_t da[5] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h0};
		dev_t dc[5] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
		for (int i = 0; i < 5; i++) begin
			do_reset();
			col_req(ca[i], da[i], 5'h01);
			col_req(col_write, 2'h0, 5'h01);
			col_req(col_read, dc[i], 5'h01);
			idle();
			if (i == 0) begin
				chk_gap("wwr count", 4, pc.size());
				chk_val("retire cmd", column_no_operation, pk[2]);
				chk_gap("retire gap", `T_CC_CYC, pc[2] - pc[1]);
				chk_gap("read gap", `T_RTR_CYC, pc[3] - pc[2]);
				chk_val("read cmd", col_read, pk[3]);
			end else begin
				chk_gap("wr rd count", 3, pc.size());
				chk_gap("wr rd gap", `T_CC_CYC, pc[2] - pc[1]);
			end
		end
	endtask
	task automatic sc_act;
		do_reset();
		col_req(col_read, 2'h1, 5'h09);
		cv <= 1'b0;
		row_req(row_activate, 2'h0, 5'h05);
		row_req(row_activate, 2'h0, 5'h05);
		row_req(row_activate, 2'h0, 5'h06);
		row_req(refresh_activate_cmd, 2'h0, 5'h04);
		row_req(row_activate, 2'h1, 5'h05);
		idle();
		chk_gap("col to row", 1, rcq[0] - pc[0]);
		chk_gap("act sent", 2, rcq.size());
		chk_gap("act rejected", 3, rjq.size());
		chk_val("row addr", 8'h05, raddr[7:0]);
	endtask
	task automatic sc_pre;
		row_cmd_e p[2] = '{row_precharge_cmd, refresh_precharge_cmd};
		for (int i = 0; i < 2; i++) begin
			do_reset();
			row_req(row_activate, 2'h0, 5'h05);
			rv <= 1'b0;
			col_req(col_read, 2'h0, 5'h05);
			cv <= 1'b0;
			row_req(p[i], 2'h0, 5'h06);
			idle();
			chk_val("read to pre", 8'h01, {7'h0, rcq[1] - pc[0] >= `T_RDP_CYC});
		end
	endtask
	task automatic sc_retire;
		do_reset();
		row_req(row_activate, 2'h0, 5'h05);
		rv <= 1'b0;
		col_req(col_write, 2'h0, 5'h05);
		fork
			begin
				row_req(row_precharge_cmd, 2'h0, 5'h04);
				rv <= 1'b0;
			end
			begin
				cv <= 1'b0;
				repeat (4) @(posedge clk_in);
				col_req(column_no_operation, 2'h2, 5'h00);
			end
		join
		idle();
		chk_val("retire to pre", 8'h01, {7'h0, rcq[1] - pc[1] >= `T_RTP_CYC});
		chk_val("forced retire", column_no_operation, pk[1]);
	endtask
	initial begin
		resetn_in = 1'b0;
		cv = 1'b0;
		rv = 1'b0;
		cc = column_no_operation;
		rc = row_no_operation;
		cd = '0;
		cb = '0;
		rd = '0;
		rb = '0;
		sc_pairs();
		sc_three();
		sc_act();
		sc_pre();
		sc_retire();
		chk_gap("device faults", 0, bad);
		end_sim();
	end
endmodule // test_col_spacing_ctrl
`default_nettype wire
